/* File: shared/uart_regs_pkg.sv */
package uart_regs_pkg;

   // Register offsets on the host register port
   localparam logic [3:0] OFS_HOLD    = 4'h0;
   localparam logic [3:0] OFS_IER     = 4'h1;
   localparam logic [3:0] OFS_IIR_FCR = 4'h2;
   localparam logic [3:0] OFS_LCR     = 4'h3;
   localparam logic [3:0] OFS_MCR     = 4'h4;
   localparam logic [3:0] OFS_LSR     = 4'h5;
   localparam logic [3:0] OFS_MSR     = 4'h6;
   localparam logic [3:0] OFS_SPR     = 4'h7;
   localparam logic [3:0] OFS_TX_FILL_COUNT   = 4'h8;
   localparam logic [3:0] OFS_RX_FILL_COUNT   = 4'h9;
   localparam logic [3:0] OFS_EXTRA_FEATURES_REG    = 4'hF;

   // Line control value that opens the enhanced bank
   localparam logic [7:0] LCR_ENH_KEY = 8'hBF;

   // Field positions
   localparam int LCR_DLAB      = 7;
   localparam int MCR_PRESCALE  = 7;
   localparam int MCR_THRESH_EN = 2;
   localparam int EFR_ENH       = 4;
   localparam int FCR_FIFO_EN   = 0;
   localparam int FCR_RX_RST    = 1;
   localparam int FCR_TX_RST    = 2;
   localparam int FCR_RXTRIG_LO = 6;
   localparam int FCR_TXTRIG_LO = 4;

   // Bits that only move while enhanced functions are on
   localparam logic [7:0] IER_ENH_MASK  = 8'hF0;
   localparam logic [7:0] MCR_ENH_MASK  = 8'hE4;
   localparam logic [7:0] FCR_ENH_MASK  = 8'h30;
   localparam logic [7:0] IIR_ENH_MASK  = 8'h30;
   // Reserved bits, stored and read as zero
   localparam logic [7:0] MCR_RSVD_MASK  = 8'h09;
   localparam logic [7:0] EXTRA_FEATURES_REG_RSVD_MASK = 8'h48;

   // Reset values
   localparam logic [7:0]  RST_REG8  = 8'h00;
   localparam logic [15:0] RST_DIV   = 16'h0000;
   localparam logic [1:0]  RST_TRIG  = 2'h0;

   // Baud generation
   localparam logic [1:0] PRESCALE_LAST = 2'h3;   // Divide by four
   localparam int         OVERSAMPLE    = 16;
   // Host-side programming figures for a 3.072 MHz reference
   localparam int          REF_CLK_HZ    = 3072000;
   localparam logic [15:0] DIV_9600      = 16'h0014;
   localparam logic [15:0] DIV_38400     = 16'h0005;
   localparam int          FIFO_RST_WAIT = 2;     // Reference clocks

   typedef enum logic [4:0] {
      SEL_NONE  = 5'h00, SEL_HOLD  = 5'h01, SEL_IER   = 5'h02,
      SEL_IIR   = 5'h03, SEL_LCR   = 5'h04, SEL_MCR   = 5'h05,
      SEL_LSR   = 5'h06, SEL_MSR   = 5'h07, SEL_SPR   = 5'h08,
      SEL_TCR   = 5'h09, SEL_TLR   = 5'h0A, SEL_TX_FILL_COUNT = 5'h0B,
      SEL_RX_FILL_COUNT = 5'h0C, SEL_EXTRA_FEATURES_REG  = 5'h0D, SEL_DLL   = 5'h0E,
      SEL_DLH   = 5'h0F, SEL_EFR   = 5'h10, SEL_RESUME_CHAR_1  = 5'h11,
      SEL_RESUME_CHAR_2  = 5'h12, SEL_PAUSE_CHAR_1 = 5'h13, SEL_PAUSE_CHAR_2 = 5'h14
   } reg_sel_t;

   typedef struct packed {
      logic [7:0]  irqEnable;
      logic [7:0]  lineCtrl;
      logic [7:0]  modemCtrl;
      logic [1:0]  rxTrig;
      logic [1:0]  txTrig;
      logic        fifoEn;
      logic [7:0]  enhFeature;
      logic [7:0]  extraFeatures;
      logic [7:0]  flowThreshold;
      logic [7:0]  fifoTrigger;
      logic [7:0]  resume1;
      logic [7:0]  resume2;
      logic [7:0]  pause1;
      logic [7:0]  pause2;
      logic [15:0] baudDiv;
   } uart_cfg_t;

   typedef struct packed {
      logic [7:0] rxChar;
      logic [7:0] lineStat;
      logic [4:0] irqCode;
      logic       irqStatus;
      logic [7:0] modemStat;
      logic [7:0] txFill;
      logic [7:0] rxFill;
   } uart_stat_t;

endpackage : uart_regs_pkg

/* File: verilog/baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module baud_gen (
   input  wire logic        sys_clk,    // System clock
   input  wire logic        resetn,     // Synchronous reset, low
   input  wire logic [15:0] divisor,    // Baud divisor
   input  wire logic        prescale4,  // Divide reference by four
   output logic             tick        // 16x baud enable pulse
);

   logic [1:0]  preCnt_q;
   logic [15:0] divCnt_q;
   logic        preEn;

   // Prescaler enable, every cycle or one in four
   assign preEn = !prescale4 || (preCnt_q == uart_regs_pkg::PRESCALE_LAST);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         preCnt_q <= 2'h0;
      end else begin
         preCnt_q <= prescale4 ? preCnt_q + 2'h1 : 2'h0;
      end
   end

   // Divisor counter; zero divisor starves the UART of ticks
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         divCnt_q <= 16'h0000;
         tick     <= 1'b0;
      end else if (divisor == 16'h0000) begin
         divCnt_q <= 16'h0000;
         tick     <= 1'b0;
      end else if (preEn) begin
         if (divCnt_q >= divisor - 16'h0001) begin
            divCnt_q <= 16'h0000;
            tick     <= 1'b1;
         end else begin
            divCnt_q <= divCnt_q + 16'h0001;
            tick     <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end

endmodule : baud_gen
`default_nettype wire

/* File: verilog/reg_select.sv */
`timescale 1ns/1ps
`default_nettype none
module reg_select (
   input  wire logic [3:0]            offset,    // Register offset
   input  wire logic [7:0]            lineCtrl,  // Line control value
   input  wire logic                  enhOn,     // Enhanced functions bit
   input  wire logic                  threshOn,  // Threshold register enable
   output uart_regs_pkg::reg_sel_t    sel        // Selected register
);

   logic enhBank;
   logic divBank;
   logic flowBank;

   // Enhanced key wins over the divisor latch enable
   assign enhBank  = (lineCtrl == uart_regs_pkg::LCR_ENH_KEY);
   assign divBank  = lineCtrl[uart_regs_pkg::LCR_DLAB] && !enhBank;
   assign flowBank = enhOn && threshOn;

   // Offset decode per bank
   always_comb begin
      sel = uart_regs_pkg::SEL_NONE;
      unique case (offset)
         uart_regs_pkg::OFS_HOLD: begin
            if (divBank) sel = uart_regs_pkg::SEL_DLL;
            else if (!enhBank) sel = uart_regs_pkg::SEL_HOLD;
         end
         uart_regs_pkg::OFS_IER: begin
            if (divBank) sel = uart_regs_pkg::SEL_DLH;
            else if (!enhBank) sel = uart_regs_pkg::SEL_IER;
         end
         uart_regs_pkg::OFS_IIR_FCR: begin
            sel = enhBank ? uart_regs_pkg::SEL_EFR : uart_regs_pkg::SEL_IIR;
         end
         uart_regs_pkg::OFS_LCR: sel = uart_regs_pkg::SEL_LCR;
         uart_regs_pkg::OFS_MCR: begin
            sel = enhBank ? uart_regs_pkg::SEL_RESUME_CHAR_1 : uart_regs_pkg::SEL_MCR;
         end
         uart_regs_pkg::OFS_LSR: begin
            sel = enhBank ? uart_regs_pkg::SEL_RESUME_CHAR_2 : uart_regs_pkg::SEL_LSR;
         end
         uart_regs_pkg::OFS_MSR: begin
            if (enhBank) sel = uart_regs_pkg::SEL_PAUSE_CHAR_1;
            else if (flowBank) sel = uart_regs_pkg::SEL_TCR;
            else sel = uart_regs_pkg::SEL_MSR;
         end
         uart_regs_pkg::OFS_SPR: begin
            if (enhBank) sel = uart_regs_pkg::SEL_PAUSE_CHAR_2;
            else if (flowBank) sel = uart_regs_pkg::SEL_TLR;
            else sel = uart_regs_pkg::SEL_SPR;
         end
         uart_regs_pkg::OFS_TX_FILL_COUNT: sel = uart_regs_pkg::SEL_TX_FILL_COUNT;
         uart_regs_pkg::OFS_RX_FILL_COUNT: sel = uart_regs_pkg::SEL_RX_FILL_COUNT;
         uart_regs_pkg::OFS_EXTRA_FEATURES_REG:  sel = uart_regs_pkg::SEL_EXTRA_FEATURES_REG;
         default:                  sel = uart_regs_pkg::SEL_NONE;
      endcase
   end

endmodule : reg_select
`default_nettype wire

/* File: verilog/uart_register_select_map.sv */
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - Offset 0 reads oldest received char, writes load the transmit path.
// - Offset 2 reads identification with FIFO enable mirror; writes FIFO control.
// - Offset 5 reads line status bits from the UART core.
// - Modem status is read-only; writes there change nothing.
// - Transmit and receive fill counts are read-only.
// - Prescaler select bit changes only while enhanced functions are on.
// - Threshold and trigger registers need enhanced bit and threshold enable.
// - Divisor bytes reachable only while divisor latch enable is set.
// - Enhanced, resume and pause registers reachable only when line control is 0xBF.
// - Interrupt enable holds eight enable bits at offset 1.
// - FIFO control carries triggers, FIFO resets and FIFO enable.
// - Line control holds divisor enable, break, parity, stop and word length.
// - Modem control holds prescale, infrared, any-resume, loopback, threshold, RTS.
// - Enhanced-only bits change only while enhanced functions are on.
// - Baud tick is reference, optionally quartered, divided by the divisor.
// - Zero divisor gives no baud tick.
module uart_register_select_map (
   input  wire logic                     sys_clk,      // System clock
   input  wire logic                     resetn,       // Synchronous reset, low
   input  wire logic [3:0]               regOffset,    // Register offset
   input  wire logic                     regWrite,     // Write strobe, one cycle
   input  wire logic                     regRead,      // Read strobe, one cycle
   input  wire logic [7:0]               regWdata,     // Write data
   output logic [7:0]                    regRdata,     // Read data, next cycle
   input  wire uart_regs_pkg::uart_stat_t stat,        // Status from the UART core
   output uart_regs_pkg::uart_cfg_t      cfg,          // Configuration to the core
   output logic [7:0]                    txChar,       // Character for transmit path
   output logic                          txLoad,       // Transmit load pulse
   output logic                          rxPop,        // Receive pop pulse
   output logic                          txFifoReset,  // Transmit FIFO reset pulse
   output logic                          rxFifoReset,  // Receive FIFO reset pulse
   output logic                          baudTick      // 16x baud enable pulse
);

   uart_regs_pkg::reg_sel_t sel;

   logic [7:0]  irqEnable_q;
   logic [7:0]  lineCtrl_q;
   logic [7:0]  modemCtrl_q;
   logic [1:0]  rxTrig_q;
   logic [1:0]  txTrig_q;
   logic        fifoEn_q;
   logic [7:0]  enhFeature_q;
   logic [7:0]  extraFeatures_q;
   logic [7:0]  scratch_q;
   logic [7:0]  flowThreshold_q;
   logic [7:0]  fifoTrigger_q;
   logic [7:0]  resume1_q;
   logic [7:0]  resume2_q;
   logic [7:0]  pause1_q;
   logic [7:0]  pause2_q;
   logic [15:0] baudDiv_q;
   logic [7:0]  readVal;
   logic [7:0]  fcrPacked;
   logic [7:0]  fcrMerged;
   logic        enhOn;

   // Keep locked bits unless unlocked; reserved bits are left for the caller to drop
   function automatic logic [7:0] mergeBits(input logic [7:0] oldV,
                                            input logic [7:0] newV,
                                            input logic [7:0] lockMask,
                                            input logic       unlock);
      logic [7:0] keep;
      keep = unlock ? 8'h00 : lockMask;
      return (newV & ~keep) | (oldV & keep);
   endfunction : mergeBits

   // Write strobe qualified by the selected register
   function automatic logic hit(input uart_regs_pkg::reg_sel_t s,
                                input uart_regs_pkg::reg_sel_t want,
                                input logic                    strobe);
      return strobe && (s == want);
   endfunction : hit

   assign enhOn = enhFeature_q[uart_regs_pkg::EFR_ENH];

   reg_select u_reg_select (
      .offset   (regOffset),
      .lineCtrl (lineCtrl_q),
      .enhOn    (enhOn),
      .threshOn (modemCtrl_q[uart_regs_pkg::MCR_THRESH_EN]),
      .sel      (sel)
   );

   baud_gen u_baud_gen (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .divisor   (baudDiv_q),
      .prescale4 (modemCtrl_q[uart_regs_pkg::MCR_PRESCALE]),
      .tick      (baudTick)
   );

   // Interrupt enable; upper nibble gated by enhanced functions
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         irqEnable_q <= uart_regs_pkg::RST_REG8;
      end else if (hit(sel, uart_regs_pkg::SEL_IER, regWrite)) begin
         irqEnable_q <= mergeBits(irqEnable_q, regWdata,
                                  uart_regs_pkg::IER_ENH_MASK, enhOn);
      end
   end

   // Line control, reachable in every bank so software can always leave one
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         lineCtrl_q <= uart_regs_pkg::RST_REG8;
      end else if (hit(sel, uart_regs_pkg::SEL_LCR, regWrite)) begin
         lineCtrl_q <= regWdata;
      end
   end

   // Modem control; prescale and other flagged bits need enhanced on
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         modemCtrl_q <= uart_regs_pkg::RST_REG8;
      end else if (hit(sel, uart_regs_pkg::SEL_MCR, regWrite)) begin
         modemCtrl_q <= mergeBits(modemCtrl_q,
                                  regWdata & ~uart_regs_pkg::MCR_RSVD_MASK,
                                  uart_regs_pkg::MCR_ENH_MASK, enhOn);
      end
   end

   // FIFO control fields packed so the merge can lock the transmit trigger
   assign fcrPacked = {rxTrig_q, txTrig_q, 3'h0, fifoEn_q};
   assign fcrMerged = mergeBits(fcrPacked, regWdata,
                                uart_regs_pkg::FCR_ENH_MASK, enhOn);

   // Stored FIFO control; bit 3 is dropped
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rxTrig_q <= uart_regs_pkg::RST_TRIG;
         txTrig_q <= uart_regs_pkg::RST_TRIG;
         fifoEn_q <= 1'b0;
      end else if (hit(sel, uart_regs_pkg::SEL_IIR, regWrite)) begin
         rxTrig_q <= fcrMerged[uart_regs_pkg::FCR_RXTRIG_LO +: 2];
         txTrig_q <= fcrMerged[uart_regs_pkg::FCR_TXTRIG_LO +: 2];
         fifoEn_q <= fcrMerged[uart_regs_pkg::FCR_FIFO_EN];
      end
   end

   // FIFO reset pulses; self-clearing, never stored
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         txFifoReset <= 1'b0;
         rxFifoReset <= 1'b0;
      end else begin
         txFifoReset <= hit(sel, uart_regs_pkg::SEL_IIR, regWrite)
                        && regWdata[uart_regs_pkg::FCR_TX_RST];
         rxFifoReset <= hit(sel, uart_regs_pkg::SEL_IIR, regWrite)
                        && regWdata[uart_regs_pkg::FCR_RX_RST];
      end
   end

   // Enhanced bank registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         enhFeature_q <= uart_regs_pkg::RST_REG8;
         resume1_q    <= uart_regs_pkg::RST_REG8;
         resume2_q    <= uart_regs_pkg::RST_REG8;
         pause1_q     <= uart_regs_pkg::RST_REG8;
         pause2_q     <= uart_regs_pkg::RST_REG8;
      end else begin
         if (hit(sel, uart_regs_pkg::SEL_EFR, regWrite))   enhFeature_q <= regWdata;
         if (hit(sel, uart_regs_pkg::SEL_RESUME_CHAR_1, regWrite))  resume1_q    <= regWdata;
         if (hit(sel, uart_regs_pkg::SEL_RESUME_CHAR_2, regWrite))  resume2_q    <= regWdata;
         if (hit(sel, uart_regs_pkg::SEL_PAUSE_CHAR_1, regWrite)) pause1_q     <= regWdata;
         if (hit(sel, uart_regs_pkg::SEL_PAUSE_CHAR_2, regWrite)) pause2_q     <= regWdata;
      end
   end

   // Flow threshold and trigger level, gated by the decoder
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flowThreshold_q <= uart_regs_pkg::RST_REG8;
         fifoTrigger_q   <= uart_regs_pkg::RST_REG8;
      end else begin
         if (hit(sel, uart_regs_pkg::SEL_TCR, regWrite)) flowThreshold_q <= regWdata;
         if (hit(sel, uart_regs_pkg::SEL_TLR, regWrite)) fifoTrigger_q   <= regWdata;
      end
   end

   // Divisor latch bytes
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         baudDiv_q <= uart_regs_pkg::RST_DIV;
      end else begin
         if (hit(sel, uart_regs_pkg::SEL_DLL, regWrite)) baudDiv_q[7:0]  <= regWdata;
         if (hit(sel, uart_regs_pkg::SEL_DLH, regWrite)) baudDiv_q[15:8] <= regWdata;
      end
   end

   // Scratch and extra features; extra features reserved bits dropped
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         scratch_q       <= uart_regs_pkg::RST_REG8;
         extraFeatures_q <= uart_regs_pkg::RST_REG8;
      end else begin
         if (hit(sel, uart_regs_pkg::SEL_SPR, regWrite)) scratch_q <= regWdata;
         if (hit(sel, uart_regs_pkg::SEL_EXTRA_FEATURES_REG, regWrite)) begin
            extraFeatures_q <= regWdata & ~uart_regs_pkg::EXTRA_FEATURES_REG_RSVD_MASK;
         end
      end
   end

   // Transmit load and receive pop; separate storage behind one offset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         txChar <= uart_regs_pkg::RST_REG8;
         txLoad <= 1'b0;
         rxPop  <= 1'b0;
      end else begin
         txLoad <= hit(sel, uart_regs_pkg::SEL_HOLD, regWrite);
         rxPop  <= hit(sel, uart_regs_pkg::SEL_HOLD, regRead);
         if (hit(sel, uart_regs_pkg::SEL_HOLD, regWrite)) begin
            txChar <= regWdata;
         end
      end
   end

   // Read mux; status registers have no write path at all
   always_comb begin
      readVal = 8'h00;
      unique case (sel)
         uart_regs_pkg::SEL_HOLD:  readVal = stat.rxChar;
         uart_regs_pkg::SEL_IER:   readVal = irqEnable_q;
         uart_regs_pkg::SEL_IIR:   readVal = {fifoEn_q, fifoEn_q, stat.irqCode, stat.irqStatus}
                                             & ~(enhOn ? 8'h00 : uart_regs_pkg::IIR_ENH_MASK);
         uart_regs_pkg::SEL_LCR:   readVal = lineCtrl_q;
         uart_regs_pkg::SEL_MCR:   readVal = modemCtrl_q;
         uart_regs_pkg::SEL_LSR:   readVal = stat.lineStat;
         uart_regs_pkg::SEL_MSR:   readVal = stat.modemStat;
         uart_regs_pkg::SEL_SPR:   readVal = scratch_q;
         uart_regs_pkg::SEL_TCR:   readVal = flowThreshold_q;
         uart_regs_pkg::SEL_TLR:   readVal = fifoTrigger_q;
         uart_regs_pkg::SEL_TX_FILL_COUNT: readVal = stat.txFill;
         uart_regs_pkg::SEL_RX_FILL_COUNT: readVal = stat.rxFill;
         uart_regs_pkg::SEL_EXTRA_FEATURES_REG:  readVal = extraFeatures_q;
         uart_regs_pkg::SEL_DLL:   readVal = baudDiv_q[7:0];
         uart_regs_pkg::SEL_DLH:   readVal = baudDiv_q[15:8];
         uart_regs_pkg::SEL_EFR:   readVal = enhFeature_q;
         uart_regs_pkg::SEL_RESUME_CHAR_1:  readVal = resume1_q;
         uart_regs_pkg::SEL_RESUME_CHAR_2:  readVal = resume2_q;
         uart_regs_pkg::SEL_PAUSE_CHAR_1: readVal = pause1_q;
         uart_regs_pkg::SEL_PAUSE_CHAR_2: readVal = pause2_q;
         default:                  readVal = 8'h00;
      endcase
   end

   // Read data register; holds its value between reads
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         regRdata <= readVal;
      end
   end

   // Configuration out to the UART core
   assign cfg.irqEnable     = irqEnable_q;
   assign cfg.lineCtrl      = lineCtrl_q;
   assign cfg.modemCtrl     = modemCtrl_q;
   assign cfg.rxTrig        = rxTrig_q;
   assign cfg.txTrig        = txTrig_q;
   assign cfg.fifoEn        = fifoEn_q;
   assign cfg.enhFeature    = enhFeature_q;
   assign cfg.extraFeatures = extraFeatures_q;
   assign cfg.flowThreshold = flowThreshold_q;
   assign cfg.fifoTrigger   = fifoTrigger_q;
   assign cfg.resume1       = resume1_q;
   assign cfg.resume2       = resume2_q;
   assign cfg.pause1        = pause1_q;
   assign cfg.pause2        = pause2_q;
   assign cfg.baudDiv       = baudDiv_q;

endmodule : uart_register_select_map
`default_nettype wire

/* File: bench/uart_register_select_map_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_register_select_map_sva (
   input wire logic                      sys_clk,     // Clock
   input wire logic                      resetn,      // Reset, low
   input wire logic [3:0]                regOffset,   // Offset
   input wire logic                      regWrite,    // Write strobe
   input wire logic                      regRead,     // Read strobe
   input wire logic [7:0]                regWdata,    // Write data
   input wire logic [7:0]                regRdata,    // Read data
   input wire uart_regs_pkg::uart_stat_t stat,        // Core status
   input wire uart_regs_pkg::uart_cfg_t  cfg,         // Configuration
   input wire logic [7:0]                txChar,      // Transmit char
   input wire logic                      txLoad,      // Transmit pulse
   input wire logic                      rxPop,       // Receive pulse
   input wire logic                      txFifoReset, // FIFO reset
   input wire logic                      rxFifoReset, // FIFO reset
   input wire logic                      baudTick     // Baud tick
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Bank decode, kept apart from the design's own decoder
   wire logic enh  = cfg.lineCtrl == 8'hBF;
   wire logic dlab = cfg.lineCtrl[7] && !enh;
   wire logic lock = !cfg.enhFeature[4];
   AST_TXLOAD: assert property (regWrite && regOffset == 4'h0 && !cfg.lineCtrl[7]
      |=> txLoad && txChar == $past(regWdata)) else $error("no transmit load");
   AST_RXPOP: assert property (regRead && regOffset == 4'h0
      |=> rxPop == !$past(cfg.lineCtrl[7])) else $error("bad receive pop");
   AST_LSR: assert property (regRead && regOffset == 4'h5 && !enh
      |=> regRdata == $past(stat.lineStat)) else $error("bad line status");
   AST_IIR: assert property (regRead && regOffset == 4'h2 && !enh
      |=> regRdata == $past({{2{cfg.fifoEn}}, stat.irqCode & {{2{!lock}}, 3'h7},
      stat.irqStatus})) else $error("bad identification");
   AST_LOCK: assert property (lock |=> $stable(cfg.modemCtrl[7:5])
      && $stable(cfg.modemCtrl[2]) && $stable(cfg.irqEnable[7:4]) && $stable(cfg.txTrig))
      else $error("locked bit moved");
   AST_DIV: assert property (regWrite && regOffset == 4'h0 && dlab
      |=> cfg.baudDiv[7:0] == $past(regWdata)) else $error("divisor not written");
   AST_DIVHOLD: assert property ($changed(cfg.baudDiv)
      |-> $past(regWrite && dlab && regOffset[3:1] == 3'h0)) else $error("divisor moved");
   AST_EFR: assert property ($changed(cfg.enhFeature)
      |-> $past(regWrite && enh && regOffset == 4'h2)) else $error("feature word moved");
   AST_ZERO: assert property (cfg.baudDiv == 16'h0000 && $past(cfg.baudDiv) == 16'h0000
      |-> !baudTick) else $error("tick with zero divisor");
   AST_TICK: assert property (baudTick && cfg.baudDiv == 16'h0005 && !cfg.modemCtrl[7]
      |=> !baudTick [*4] ##1 baudTick) else $error("bad tick period");
   // Main scenarios reached
   cover property (txLoad);
   cover property (baudTick);
   cover property (regRead && enh);
endmodule : uart_register_select_map_sva
bind uart_register_select_map uart_register_select_map_sva chk (.sys_clk(sys_clk),
   .resetn(resetn), .regOffset(regOffset), .regWrite(regWrite), .regRead(regRead),
   .regWdata(regWdata), .regRdata(regRdata), .stat(stat), .cfg(cfg), .txChar(txChar),
   .txLoad(txLoad), .rxPop(rxPop), .txFifoReset(txFifoReset), .rxFifoReset(rxFifoReset),
   .baudTick(baudTick));
`default_nettype wire

/* File: bench/uart_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_host_model (
   input  wire logic       sys_clk,   // Clock
   input  wire logic [7:0] regRdata,  // Read data
   output logic [3:0]      regOffset, // Offset
   output logic            regWrite,  // Write strobe
   output logic            regRead,   // Read strobe
   output logic [7:0]      regWdata   // Write data
);
   // Idle bus from time zero
   initial begin
      regOffset = 4'h0;
      regWrite  = 1'b0;
      regRead   = 1'b0;
      regWdata  = 8'h00;
   end
   // One-cycle write; strobe drops on the edge that takes it
   task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
      @(posedge sys_clk);
      regOffset <= ofs;
      regWdata  <= d;
      regWrite  <= 1'b1;
      @(posedge sys_clk);
      regWrite  <= 1'b0;
   endtask : wr
   // Read data holds until the next read, so one spare edge is safe
   task automatic rd(input logic [3:0] ofs, output logic [7:0] d);
      @(posedge sys_clk);
      regOffset <= ofs;
      regRead   <= 1'b1;
      @(posedge sys_clk);
      regRead   <= 1'b0;
      @(posedge sys_clk);
      d = regRdata;
   endtask : rd
endmodule : uart_host_model
`default_nettype wire

/* File: bench/test_uart_register_select_map.sv */
`timescale 1ns/1ps
`default_nettype none
module test_uart_register_select_map;
   logic                      sys_clk;
   logic                      resetn;
   logic [3:0]                regOffset;
   logic                      regWrite;
   logic                      regRead;
   logic [7:0]                regWdata;
   logic [7:0]                regRdata;
   uart_regs_pkg::uart_stat_t stat;
   uart_regs_pkg::uart_cfg_t  cfg;
   logic [7:0]                txChar;
   logic                      txLoad;
   logic                      txFifoReset;
   logic                      rxFifoReset;
   logic                      baudTick;
   logic [7:0]                r;
   int                        error_cnt = 0;
   int                        n_compared = 0;
   int                        ticks = 0;
   // Offset, write data, expected read-back; general bank, enhanced off
   localparam logic [19:0] ROWS [10] = '{20'h1_FF0F, 20'h3_5A5A, 20'h4_FF12, 20'h7_A5A5,
      20'h5_3361, 20'h6_3310, 20'h8_3340, 20'h9_3303, 20'hB_7700, 20'hF_FFB7};
   uart_register_select_map dut (.sys_clk(sys_clk), .resetn(resetn), .regOffset(regOffset),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .stat(stat), .cfg(cfg), .txChar(txChar), .txLoad(txLoad), .rxPop(),
      .txFifoReset(txFifoReset), .rxFifoReset(rxFifoReset), .baudTick(baudTick));
   uart_host_model host (.sys_clk(sys_clk), .regRdata(regRdata), .regOffset(regOffset),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata));
   // Clock and tick counter
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (baudTick === 1'b1) ticks++;
   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Verdict and end of run
   task automatic summarize();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   // Watchdog far beyond the expected few hundred cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end
   initial begin
      resetn = 1'b0;
      stat   = {8'hC3, 8'h61, 5'h1B, 1'b1, 8'h10, 8'h40, 8'h03};
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      foreach (ROWS[i]) begin
         host.wr(ROWS[i][19:16], ROWS[i][15:8]);
         host.rd(ROWS[i][19:16], r);
         chk({8'h00, r}, {8'h00, ROWS[i][7:0]});
      end
      // Enhanced bank behind the key value
      host.wr(4'h3, 8'hBF);
      host.wr(4'h2, 8'h10);
      host.wr(4'h4, 8'h11);
      host.rd(4'h4, r);
      chk({8'h00, r}, 16'h0011);
      host.rd(4'h0, r);
      chk({8'h00, r}, 16'h0000);
      // Enhanced functions on: locked bits now move
      host.wr(4'h3, 8'h00);
      host.wr(4'h1, 8'hFF);
      host.wr(4'h4, 8'h84);
      #1 chk({cfg.irqEnable, cfg.modemCtrl}, 16'hFF84);
      host.wr(4'h4, 8'h04);
      host.wr(4'h6, 8'h5C);
      host.rd(4'h6, r);
      chk({8'h00, r}, 16'h005C);
      host.wr(4'h4, 8'h00);
      host.rd(4'h6, r);
      chk({8'h00, r}, 16'h0010);
      host.wr(4'h2, 8'hF7);
      #1 chk({10'h000, cfg.rxTrig, cfg.txTrig, txFifoReset, rxFifoReset}, 16'h003F);
      repeat (2) @(posedge sys_clk);
      host.rd(4'h2, r);
      chk({8'h00, r}, 16'h00F7);
      // Divisor for 38400 baud, then tick rate
      host.wr(4'h3, 8'h80);
      host.wr(4'h1, 8'h00);
      host.wr(4'h0, uart_regs_pkg::DIV_38400[7:0]);
      host.rd(4'h0, r);
      chk({8'h00, r}, 16'h0005);
      #1 ticks = 0;
      repeat (50) @(posedge sys_clk);
      #1 chk(16'(ticks), 16'h000A);
      // Prescale by four: one tick every twenty cycles once settled
      host.wr(4'h4, 8'h80);
      repeat (25) @(posedge sys_clk);
      #1 ticks = 0;
      repeat (100) @(posedge sys_clk);
      #1 chk(16'(ticks), 16'h0005);
      // Holding location in the general bank
      host.wr(4'h3, 8'h03);
      host.wr(4'h0, 8'h3C);
      #1 chk({txLoad, 7'h00, txChar}, 16'h803C);
      host.rd(4'h0, r);
      chk({8'h00, r}, 16'h00C3);
      // Mid-run reset clears everything and stops ticks
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      #1 ticks = 0;
      repeat (20) @(posedge sys_clk);
      #1 chk(16'(ticks) | 16'(cfg != '0), 16'h0000);
      summarize();
   end
endmodule : test_uart_register_select_map
`default_nettype wire
